// ==== dv/pif_evt_src.sv ====
`default_nettype none
module pif_evt_src (
    // Clock
    input  wire logic       mclk,
    // Stimulus from bench
    input  wire logic       fire,
    input  wire logic [3:0] cell_v,
    input  wire logic [7:0] bank_v,
    // Event pulses into the block
    output logic      [3:0] cell_evt,
    output logic      [7:0] bank1_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered so each event is exactly one clean cycle long
    always_ff @(posedge mclk)
    begin
        cell_evt  <= fire ? cell_v : 4'h0;
        bank1_evt <= fire ? bank_v : 8'h00;
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("wrong value at %0t: got %h expected %h", $time, g, e); \
        end \
    end
module tb_top import pif_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, rst_b, reg_wr, reg_rd, fire, m, core_irq_req_q, irq_q;
    logic [3:0] reg_addr, cell_v, cell_evt, cell_irq_req_q, en, ev;
    logic [7:0] reg_wdata, bank_v, bank1_evt, reg_rdata_q, d;
    logic [31:0] seed = 32'h896A6F27;
    int         fails = 0;
    int         checked = 0;
    int         k;
    int         mdl_en;
    int         mdl_ctrl;
    int         cell_hist_q[$];
    pif_evt_src evt_u (.mclk(mclk), .fire(fire), .cell_v(cell_v), .bank_v(bank_v),
        .cell_evt(cell_evt), .bank1_evt(bank1_evt));
    pif_irq_enable_flags dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .cell_evt(cell_evt), .bank1_evt(bank1_evt), .core_irq_req_q(core_irq_req_q),
        .cell_irq_req_q(cell_irq_req_q), .irq_q(irq_q));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Reference model: cell flags are the OR of all events since the last clear
    function automatic int mdl_cell();
        int acc = 0;
        foreach (cell_hist_q[i])
            acc |= cell_hist_q[i];
        return acc;
    endfunction
    function automatic int mdl_req();
        if (((mdl_ctrl >> PIF_MASTER_EN_BIT) & 1) == 0)
            return 0;
        return mdl_cell() & mdl_en;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Strobe drops one edge before the next may rise, so no double drive
    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        if (a == PIF_OFF_ENABLE3)
            mdl_en = int'(w) & 'hF;
        if (a == PIF_OFF_CORE_CTRL)
            mdl_ctrl = int'(w) & (1 << PIF_MASTER_EN_BIT);
        if (a == PIF_OFF_CELL_RAW && w[3:0] == 4'h0)
            cell_hist_q.delete();
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= w;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 r = reg_rdata_q;
    endtask
    task automatic pulse(input logic [3:0] c, input logic [7:0] b);
        cell_hist_q.push_back(int'(c));
        @(posedge mclk);
        fire   <= 1'b1;
        cell_v <= c;
        bank_v <= b;
        @(posedge mclk);
        fire   <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        mdl_en   = 0;
        mdl_ctrl = 0;
        cell_hist_q.delete();
        for (int i = 0; i < 6; i++)
        begin
            rd(4'(i), d);
            `CHK(d, PIF_RESET_VALUE)
        end
        rd(4'hF, d);
        `CHK({d, irq_q, core_irq_req_q}, 10'h000)
    endtask
    initial
    begin
        {rst_b, reg_wr, reg_rd, fire, reg_addr, reg_wdata, cell_v, bank_v} = '0;
        do_reset();
        wr(PIF_OFF_ENABLE3, 8'hFF);
        rd(PIF_OFF_ENABLE3, d);
        `CHK(d, 8'(mdl_en))
        repeat (4)
        begin
            k = int'(rnd() & 32'hFF);
            wr(PIF_OFF_REQUEST1, 8'(k));
            rd(PIF_OFF_REQUEST1, d);
            `CHK(d, 8'(k) & PIF_REQUEST1_WMASK)
        end
        // Hardware events set flags even the software cannot write
        pulse(4'h0, 8'hFF);
        rd(PIF_OFF_REQUEST1, d);
        `CHK(d, PIF_REQUEST1_IMPL)
        repeat (16)
        begin
            {m, ev, en} = 9'(rnd());
            wr(PIF_OFF_CELL_RAW, 8'h00);
            wr(PIF_OFF_ENABLE3, {4'h0, en});
            wr(PIF_OFF_CORE_CTRL, {1'b0, m, 6'h00});
            pulse(ev, 8'h00);
            rd(PIF_OFF_CELL_RAW, d);
            `CHK(d, 8'(mdl_cell()))
            `CHK(cell_irq_req_q, 4'(mdl_req()))
            `CHK(core_irq_req_q, mdl_req() != 0)
        end
        wr(PIF_OFF_CELL_RAW, 8'h00);
        wr(PIF_OFF_IRQ_STATUS, PIF_IRQ_EVT_MASK);
        wr(PIF_OFF_IRQ_MASK, PIF_IRQ_EVT_MASK);
        wr(PIF_OFF_ENABLE3, 8'h08);
        wr(PIF_OFF_CORE_CTRL, PIF_CORE_CTRL_MASK);
        pulse(4'h8, 8'h00);
        for (k = 0; k < 8 && irq_q !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
        end
        `CHK(irq_q, 1'b1)
        if (k == 8)
            give_verdict();
        rd(PIF_OFF_IRQ_STATUS, d);
        `CHK(d, PIF_IRQ_EVT_MASK)
        wr(PIF_OFF_IRQ_MASK, 8'h00);
        @(posedge mclk);
        #1 `CHK(irq_q, 1'b0)
        wr(PIF_OFF_IRQ_MASK, PIF_IRQ_EVT_MASK);
        wr(PIF_OFF_IRQ_STATUS, PIF_IRQ_EVT_MASK);
        @(posedge mclk);
        #1 `CHK(irq_q, 1'b0)
        wr(PIF_OFF_CORE_CTRL, 8'h00);
        @(posedge mclk);
        #1 `CHK({core_irq_req_q, cell_irq_req_q}, 5'h00)
        // Mid-run reset with flags and enables still live
        wr(PIF_OFF_CORE_CTRL, PIF_CORE_CTRL_MASK);
        do_reset();
        give_verdict();
    end
endmodule
`undef CHK
`default_nettype wire

// ==== include/pif_pkg.sv ====
`default_nettype none
package pif_pkg;
    // Register word indices on the plain port
    localparam logic [3:0] PIF_ADDR_W           = 4'h4;
    localparam logic [3:0] PIF_OFF_ENABLE3      = 4'h0;
    localparam logic [3:0] PIF_OFF_REQUEST1     = 4'h1;
    localparam logic [3:0] PIF_OFF_CORE_CTRL    = 4'h2;
    localparam logic [3:0] PIF_OFF_IRQ_STATUS   = 4'h3;
    localparam logic [3:0] PIF_OFF_IRQ_MASK     = 4'h4;
    localparam logic [3:0] PIF_OFF_CELL_RAW     = 4'h5;
    // Enable bank 3 layout
    localparam int         PIF_CELL1_BIT        = 0;
    localparam int         PIF_CELL2_BIT        = 1;
    localparam int         PIF_CELL3_BIT        = 2;
    localparam int         PIF_CELL4_BIT        = 3;
    localparam logic [7:0] PIF_ENABLE3_MASK     = 8'h0F;
    // Request bank 1 layout
    localparam int         PIF_T1OVF_BIT        = 0;
    localparam int         PIF_T2MATCH_BIT      = 1;
    localparam int         PIF_SSP_BIT          = 3;
    localparam int         PIF_TX_BIT           = 4;
    localparam int         PIF_RX_BIT           = 5;
    localparam int         PIF_ADC_BIT          = 6;
    localparam int         PIF_T1GATE_BIT       = 7;
    localparam logic [7:0] PIF_REQUEST1_IMPL    = 8'hFB;
    // Receive flag is read only; hardware owns it
    localparam logic [7:0] PIF_REQUEST1_WMASK   = 8'hDB;
    // Core control layout
    localparam int         PIF_MASTER_EN_BIT    = 6;
    localparam logic [7:0] PIF_CORE_CTRL_MASK   = 8'h40;
    // Interrupt status: bit 0 = core request rising edge
    localparam logic [7:0] PIF_IRQ_EVT_MASK     = 8'h01;
    localparam logic [7:0] PIF_RESET_VALUE      = 8'h00;
endpackage
`default_nettype wire

// ==== logic/pif_irq_enable_flags.sv ====
`default_nettype none
module pif_irq_enable_flags
    import pif_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // Register port
    input  wire logic [PIF_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata_q,
    // Peripheral event pulses, same clock
    input  wire logic [3:0]            cell_evt,
    input  wire logic [7:0]            bank1_evt,
    // Requests
    output logic                       core_irq_req_q,
    output logic [3:0]                 cell_irq_req_q,
    output logic                       irq_q
);
    logic [7:0] enable3_q;
    logic [7:0] enable3_d;
    logic [7:0] core_ctrl_q;
    logic [7:0] core_ctrl_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] request1_q;
    logic [3:0] cell_flag_q;
    logic [7:0] status_q;
    logic       core_req_prev_q;

    // Address decode
    wire        wr_en3   = reg_wr && (reg_addr == PIF_OFF_ENABLE3);
    wire        wr_req1  = reg_wr && (reg_addr == PIF_OFF_REQUEST1);
    wire        wr_core  = reg_wr && (reg_addr == PIF_OFF_CORE_CTRL);
    wire        wr_stat  = reg_wr && (reg_addr == PIF_OFF_IRQ_STATUS);
    wire        wr_mask  = reg_wr && (reg_addr == PIF_OFF_IRQ_MASK);
    wire        wr_raw   = reg_wr && (reg_addr == PIF_OFF_CELL_RAW);

    // Next values of plain storage registers
    assign enable3_d   = wr_en3  ? (reg_wdata & PIF_ENABLE3_MASK)   : enable3_q;
    assign core_ctrl_d = wr_core ? (reg_wdata & PIF_CORE_CTRL_MASK) : core_ctrl_q;
    assign mask_d      = wr_mask ? (reg_wdata & PIF_IRQ_EVT_MASK)   : mask_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            enable3_q   <= PIF_RESET_VALUE;
            core_ctrl_q <= PIF_RESET_VALUE;
            mask_q      <= PIF_RESET_VALUE;
        end
        else
        begin
            enable3_q   <= enable3_d;
            core_ctrl_q <= core_ctrl_d;
            mask_q      <= mask_d;
        end
    end

    wire cell4_irq_en         = enable3_q[PIF_CELL4_BIT];
    wire cell3_irq_en         = enable3_q[PIF_CELL3_BIT];
    wire cell2_irq_en         = enable3_q[PIF_CELL2_BIT];
    wire cell1_irq_en         = enable3_q[PIF_CELL1_BIT];
    wire periph_master_irq_en = core_ctrl_q[PIF_MASTER_EN_BIT];

    // Flags set regardless of enables; software clears by writing zero.
    // Receive flag clears only on reset, so software cannot drop it.
    wire [7:0] req1_clr = wr_req1 ? (~reg_wdata & PIF_REQUEST1_WMASK) : 8'h00;
    wire [7:0] req1_set = (wr_req1 ? (reg_wdata & PIF_REQUEST1_WMASK) : 8'h00)
                          | bank1_evt;

    pif_sticky #(.WIDTH(8)) u_req1 (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .set_i  (req1_set),
        .clr_i  (req1_clr),
        .impl_i (PIF_REQUEST1_IMPL),
        .flag_q (request1_q)
    );

    // Cell flags live here as raw pending bits, cleared by writing a zero
    wire [3:0] raw_clr = wr_raw ? ~reg_wdata[3:0] : 4'h0;

    pif_sticky #(.WIDTH(4)) u_cell (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .set_i  (cell_evt),
        .clr_i  (raw_clr),
        .impl_i (4'hF),
        .flag_q (cell_flag_q)
    );

    // Gating: flag, own enable, master enable
    wire [3:0] cell_en_vec = {cell4_irq_en, cell3_irq_en, cell2_irq_en, cell1_irq_en};
    wire [3:0] cell_req_d  = cell_flag_q & cell_en_vec
                             & {4{periph_master_irq_en}};
    wire       core_req_d  = (|cell_req_d) && periph_master_irq_en;

    // Status: rising edge of the core request, write one to clear
    wire       core_rise   = core_req_d && !core_req_prev_q;
    wire [7:0] stat_set    = {7'h00, core_rise};
    wire [7:0] stat_clr    = wr_stat ? (reg_wdata & PIF_IRQ_EVT_MASK) : 8'h00;

    pif_sticky #(.WIDTH(8)) u_stat (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .set_i  (stat_set),
        .clr_i  (stat_clr),
        .impl_i (PIF_IRQ_EVT_MASK),
        .flag_q (status_q)
    );

    // Read mux; unmapped reads return zero
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr)
            PIF_OFF_ENABLE3:    rd_mux = enable3_q;
            PIF_OFF_REQUEST1:   rd_mux = request1_q;
            PIF_OFF_CORE_CTRL:  rd_mux = core_ctrl_q;
            PIF_OFF_IRQ_STATUS: rd_mux = status_q;
            PIF_OFF_IRQ_MASK:   rd_mux = mask_q;
            PIF_OFF_CELL_RAW:   rd_mux = {4'h0, cell_flag_q};
            default:            rd_mux = 8'h00;
        endcase
    end

    // Outputs from flops; one cycle of latency on every request
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            reg_rdata_q     <= 8'h00;
            core_irq_req_q  <= 1'b0;
            cell_irq_req_q  <= 4'h0;
            core_req_prev_q <= 1'b0;
            irq_q           <= 1'b0;
        end
        else
        begin
            reg_rdata_q     <= reg_rd ? rd_mux : 8'h00;
            core_irq_req_q  <= core_req_d;
            cell_irq_req_q  <= cell_req_d;
            core_req_prev_q <= core_req_d;
            irq_q           <= |(status_q & mask_q);
        end
    end

    // Checks
    sequence s_master_off;
        !periph_master_irq_en;
    endsequence

    master_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_master_off |=> !core_irq_req_q)
        else $error("core request raised with master enable off");

    cell4_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !cell4_irq_en |=> !cell_irq_req_q[3])
        else $error("cell 4 request while disabled");

    cell3_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cell3_irq_en && cell_flag_q[2] && periph_master_irq_en) |=> cell_irq_req_q[2])
        else $error("cell 3 request missing");

    cell2_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (!cell2_irq_en) |=> !cell_irq_req_q[1])
        else $error("cell 2 request while disabled");

    cell1_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cell1_irq_en && cell_flag_q[0] && periph_master_irq_en) |=> cell_irq_req_q[0])
        else $error("cell 1 request missing");

    reset_clear_a: assert property (@(posedge mclk)
        !rst_b |=> (enable3_q == 8'h00) && (request1_q == 8'h00) && !core_irq_req_q)
        else $error("registers not cleared by reset");

    request_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
        core_irq_req_q |-> $past(|(cell_flag_q & enable3_q[3:0]) && periph_master_irq_en))
        else $error("core request without flag and enables");

    enable_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_en3 |=> enable3_q == $past(reg_wdata & PIF_ENABLE3_MASK))
        else $error("enable write not stored");

    // Event to request takes two edges: flag first, then gated request
    sequence s_cell1_armed;
        cell_evt[0] && cell1_irq_en && periph_master_irq_en && !wr_en3 && !wr_core;
    endsequence

    sequence s_cell1_served;
        cell_irq_req_q[0] && core_irq_req_q;
    endsequence

    sequence s_cell4_armed;
        cell_evt[3] && cell4_irq_en && periph_master_irq_en && !wr_en3 && !wr_core;
    endsequence

    sequence s_cell4_served;
        cell_irq_req_q[3] && core_irq_req_q;
    endsequence

    cell1_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_cell1_armed |-> ##2 s_cell1_served)
        else $error("cell 1 event not served in two cycles");

    cell4_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_cell4_armed |-> ##2 s_cell4_served)
        else $error("cell 4 event not served in two cycles");

    cell4_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cell4_irq_en && cell_flag_q[3] && periph_master_irq_en) |=> cell_irq_req_q[3])
        else $error("cell 4 request missing");

    cell3_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !cell3_irq_en |=> !cell_irq_req_q[2])
        else $error("cell 3 request while disabled");

    cell2_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cell2_irq_en && cell_flag_q[1] && periph_master_irq_en) |=> cell_irq_req_q[1])
        else $error("cell 2 request missing");

    cell1_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !cell1_irq_en |=> !cell_irq_req_q[0])
        else $error("cell 1 request while disabled");

    master_cells_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_master_off |=> (cell_irq_req_q == 4'h0))
        else $error("cell request raised with master enable off");

    core_from_cells_a: assert property (@(posedge mclk) disable iff (!rst_b)
        core_irq_req_q == (|cell_irq_req_q))
        else $error("core request disagrees with cell requests");

    no_flag_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cell_flag_q == 4'h0) |=> !core_irq_req_q)
        else $error("core request without any pending flag");

    reset_outputs_a: assert property (@(posedge mclk)
        !rst_b |=> !irq_q && (cell_irq_req_q == 4'h0) && (reg_rdata_q == 8'h00))
        else $error("outputs not cleared by reset");

    reset_regs_a: assert property (@(posedge mclk)
        !rst_b |=> (core_ctrl_q == 8'h00) && (mask_q == 8'h00)
                   && (cell_flag_q == 4'h0) && (status_q == 8'h00))
        else $error("control or flag registers not cleared by reset");

    enable_spare_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (enable3_q & ~PIF_ENABLE3_MASK) == 8'h00)
        else $error("unimplemented enable bit set");

    core_spare_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (core_ctrl_q & ~PIF_CORE_CTRL_MASK) == 8'h00)
        else $error("unimplemented core control bit set");

    core_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_core |=> core_ctrl_q == $past(reg_wdata & PIF_CORE_CTRL_MASK))
        else $error("core control write not stored");

    flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !wr_raw |=> (cell_flag_q & $past(cell_flag_q)) == $past(cell_flag_q))
        else $error("cell flag lost without a clear");

    flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (|cell_evt) |=> (cell_flag_q & $past(cell_evt)) == $past(cell_evt))
        else $error("cell event did not set its flag");

    bank1_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (|bank1_evt) |=> (request1_q & $past(bank1_evt & PIF_REQUEST1_IMPL))
                         == $past(bank1_evt & PIF_REQUEST1_IMPL))
        else $error("bank 1 event did not set its flag");

    rx_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !bank1_evt[PIF_RX_BIT] |=> request1_q[PIF_RX_BIT] == $past(request1_q[PIF_RX_BIT]))
        else $error("receive flag changed without its source");

    req1_spare_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (request1_q & ~PIF_REQUEST1_IMPL) == 8'h00)
        else $error("unimplemented request bit set");

    rdata_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (reg_rd && (reg_addr == PIF_OFF_ENABLE3)) |=> reg_rdata_q == $past(enable3_q))
        else $error("enable read returned wrong data");

    status_rise_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (core_req_d && !core_req_prev_q) |=> status_q[0])
        else $error("core request edge not recorded");

    irq_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (|(status_q & mask_q)) |=> irq_q)
        else $error("interrupt missing for unmasked status");

    irq_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(|(status_q & mask_q)) |=> !irq_q)
        else $error("interrupt raised without unmasked status");
endmodule
`default_nettype wire

// ==== logic/pif_sticky.sv ====
`default_nettype none
module pif_sticky
    import pif_pkg::*;
#(
    parameter int WIDTH = 8
)(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Control
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    input  wire logic [WIDTH-1:0] impl_i,
    output logic      [WIDTH-1:0] flag_q
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            // Set beats a clear in the same cycle so no event is lost
            always_ff @(posedge mclk)
            begin
                if (!rst_b)
                    flag_q[g] <= 1'b0;
                else if (set_i[g] && impl_i[g])
                    flag_q[g] <= 1'b1;
                else if (clr_i[g])
                    flag_q[g] <= 1'b0;
            end
        end
    endgenerate
endmodule
`default_nettype wire
